// [logic/wipe_host_defines.svh]
// Constants for the flash wipe and halted-program host controller.
`ifndef WIPE_HOST_DEFINES_SVH
`define WIPE_HOST_DEFINES_SVH

`define CLK_PERIOD_NS        10
`define T_ACC_NS             70
`define T_WE_PULSE_NS        50
`define T_HALT_LATENCY_US    20
`define T_PAUSE_LATENCY_US   20
`define ACC_CYC              ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_STROBE_CYC        (`ACC_CYC + 3)
`define WR_STROBE_CYC        ((`T_WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALT_LATENCY_CYC     ((`T_HALT_LATENCY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAUSE_LATENCY_CYC    ((`T_PAUSE_LATENCY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_GAP_CYC         100

`define ADDR_UNLOCK1         23'h000555
`define ADDR_UNLOCK2         23'h0002aa
`define ADDR_ANY             23'h000000
`define SECTOR_LSB           15
`define CMD_UNLOCK1          16'h00aa
`define CMD_UNLOCK2          16'h0055
`define CMD_WIPE_ENTER       16'h0080
`define CMD_CHIP_WIPE        16'h0010
`define CMD_BLOCK_WIPE       16'h0030
`define CMD_SUSPEND          16'h00b0
`define CMD_RESUME           16'h0030
`define CMD_WORD_PROG        16'h00a0
`define CMD_BUF_ENTER        16'h0025
`define CMD_BUF_CONFIRM      16'h0029
`define CMD_PROG_PAUSE       16'h0051
`define CMD_PROG_RESUME      16'h0050
`define CMD_SOFT_RESET       16'h00f0
`define CMD_SR_READ          16'h0070
`define CMD_SR_CLEAR         16'h0071
`define CMD_QUERY            16'h0035
`define MAX_WORD_COUNT       16'd127
`define SR_READY_BIT         7
`define DQ_WINDOW_BIT        3
`define DQ_TIME_LIMIT_BIT    5

`define OP_CHIP              4'h1
`define OP_BLOCK             4'h2
`define OP_QUEUE             4'h3
`define OP_SUSPEND           4'h4
`define OP_RESUME            4'h5
`define OP_WORD              4'h6
`define OP_BUF_OPEN          4'h7
`define OP_BUF_WORD          4'h8
`define OP_BUF_CONFIRM       4'h9
`define OP_PAUSE             4'ha
`define OP_PROG_RESUME       4'hb
`define OP_RESET             4'hc
`define OP_SR_CLEAR          4'hd
`define OP_QUERY             4'he
`define OP_POLL              4'hf

`define K_END                2'h0
`define K_WRITE              2'h1
`define K_READ_SR            2'h2
`define K_READ_DQ            2'h3

`define REG_CMD              4'h0
`define REG_ADDR             4'h1
`define REG_DATA             4'h2
`define REG_STATE            4'h3
`define REG_RESULT           4'h4
`define REG_IRQ_STAT         4'h5
`define REG_IRQ_MASK         4'h6
`define EV_DONE              0
`define EV_HANG              1
`define EV_REFUSED           2
`define EV_HALTED            3

`endif

// [logic/wipe_host_pkg.sv]
// Types for the flash wipe and halted-program host controller.
package wipe_host_pkg;
  typedef enum logic [3:0] {
    read_idle, whole_array_wipe_run, block_wipe_run, wipe_halt_pending, wipe_halted,
    query_wipe_result, halted_buffer_load_words, halted_prog_run, halted_prog_pause_pending,
    halted_prog_paused, wipe_hang
  } mirror_e;
  typedef enum logic [1:0] {ph_idle, ph_fetch, ph_strobe, ph_gap} phase_e;
  typedef logic [3:0] op_t;
  typedef logic [40:0] step_t;
endpackage

// [logic/wipe_host.sv]
// Host controller that sequences wipe, halt and halted-program commands to a NOR flash.
//
// Contract
// - Unlock: AA at 555, then 55 at 2AA.
// - Then 10 at 555 or 30 at block.
// - Timeout hangs until F0 reset.
// - Halted unlock, then A0 or 25.
// - 29 at block when countdown is -1.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "wipe_host_defines.svh"

module wipe_host (
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  input  wire logic [3:0]             i_reg_addr,
  input  wire logic [31:0]            i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic [31:0]                 o_reg_rdata,
  output logic                        o_irq,
  output logic [22:0]                 o_fl_addr,
  output logic [15:0]                 o_fl_dq,
  output logic                        o_fl_dq_oe_n,
  input  wire logic [15:0]            i_fl_dq,
  output logic                        o_fl_ce_n,
  output logic                        o_fl_we_n,
  output logic                        o_fl_oe_n
);
  import wipe_host_pkg::*;

  mirror_e     mirror;
  phase_e      phase;
  op_t         op_q;
  logic [2:0]  idx;
  logic [3:0]  strobe_cnt;
  logic [1:0]  kind_q;
  logic [22:0] addr_q;
  logic [15:0] data_q;
  logic [22:0] entry_block_addr;
  logic [7:0]  word_countdown;
  logic        queue_closed;
  logic        hang_in_halt;
  logic [7:0]  status_q;
  logic [7:0]  dq_q;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [11:0] lat_cnt;
  logic [7:0]  poll_cnt;
  logic [15:0] dq_s1, dq_s2, dq_s3;
  logic        fin;
  logic        cmd_wr;
  logic        launch_sw;
  logic        launch_poll;
  logic        running;
  logic [3:0]  ev;
  step_t       step;

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequences: each step is a write, a status read or a data-poll read.

  function automatic step_t seq_step(input op_t op, input logic [2:0] i, input logic [22:0] a,
                                     input logic [15:0] d);
    logic [22:0] sa;
    logic        unl;
    step_t       s;
    sa  = {a[22:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
    unl = (op == `OP_CHIP) || (op == `OP_BLOCK) || (op == `OP_WORD) || (op == `OP_BUF_OPEN);
    s   = {`K_END, `ADDR_ANY, 16'h0000};
    if (unl && (i == 3'd0 || (i == 3'd3 && op inside {`OP_CHIP, `OP_BLOCK}))) begin
      s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_UNLOCK1};
    end else if (unl && (i == 3'd1 || (i == 3'd4 && op inside {`OP_CHIP, `OP_BLOCK}))) begin
      s = {`K_WRITE, `ADDR_UNLOCK2, `CMD_UNLOCK2};
    end else begin
      case (op)
        `OP_CHIP, `OP_BLOCK: begin
          if (i == 3'd2) s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_WIPE_ENTER};
          else if (i == 3'd5 && op == `OP_CHIP) s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_CHIP_WIPE};
          else if (i == 3'd5) s = {`K_WRITE, sa, `CMD_BLOCK_WIPE};
        end
        `OP_WORD: begin
          if (i == 3'd2) s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_WORD_PROG};
          else if (i == 3'd3) s = {`K_WRITE, a, d};
        end
        `OP_BUF_OPEN: begin
          if (i == 3'd2) s = {`K_WRITE, sa, `CMD_BUF_ENTER};
          else if (i == 3'd3) s = {`K_WRITE, sa, d};
        end
        `OP_QUEUE:       if (i == 3'd0) s = {`K_WRITE, sa, `CMD_BLOCK_WIPE};
        `OP_SUSPEND:     if (i == 3'd0) s = {`K_WRITE, `ADDR_ANY, `CMD_SUSPEND};
        `OP_RESUME:      if (i == 3'd0) s = {`K_WRITE, `ADDR_ANY, `CMD_RESUME};
        `OP_BUF_WORD:    if (i == 3'd0) s = {`K_WRITE, a, d};
        `OP_BUF_CONFIRM: if (i == 3'd0) s = {`K_WRITE, sa, `CMD_BUF_CONFIRM};
        `OP_PAUSE:       if (i == 3'd0) s = {`K_WRITE, `ADDR_ANY, `CMD_PROG_PAUSE};
        `OP_PROG_RESUME: if (i == 3'd0) s = {`K_WRITE, `ADDR_ANY, `CMD_PROG_RESUME};
        `OP_RESET:       if (i == 3'd0) s = {`K_WRITE, `ADDR_ANY, `CMD_SOFT_RESET};
        `OP_SR_CLEAR:    if (i == 3'd0) s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_SR_CLEAR};
        `OP_QUERY:       if (i == 3'd0) s = {`K_WRITE, sa | `ADDR_UNLOCK1, `CMD_QUERY};
        `OP_POLL: begin
          if (i == 3'd0) s = {`K_WRITE, `ADDR_UNLOCK1, `CMD_SR_READ};
          else if (i == 3'd1) s = {`K_READ_SR, `ADDR_ANY, 16'h0000};
          else if (i == 3'd2) s = {`K_READ_DQ, sa, 16'h0000};
        end
        default: s = {`K_END, `ADDR_ANY, 16'h0000};
      endcase
    end
    return s;
  endfunction

  // Software commands are launched only when valid for the mirrored state and the last polled status.
  function automatic logic op_legal(input op_t op, input mirror_e m, input logic rdy, input logic win,
                                    input logic qc, input logic [7:0] cd, input logic [15:0] d,
                                    input logic same_blk);
    case (op)
      `OP_CHIP, `OP_BLOCK, `OP_QUERY: return m == read_idle;
      `OP_QUEUE:       return m == block_wipe_run && !win && !qc && !rdy;
      `OP_SUSPEND:     return (m == block_wipe_run || m == halted_prog_run) && !rdy;
      `OP_RESUME, `OP_WORD, `OP_SR_CLEAR: return m == wipe_halted;
      `OP_BUF_OPEN:    return m == wipe_halted && d <= `MAX_WORD_COUNT;
      `OP_BUF_WORD:    return m == halted_buffer_load_words && !cd[7] && same_blk;
      `OP_BUF_CONFIRM: return m == halted_buffer_load_words && cd == 8'hff && same_blk;
      `OP_PAUSE:       return m == halted_prog_run && !rdy;
      `OP_PROG_RESUME: return m == halted_prog_paused;
      `OP_RESET:       return m == wipe_hang || m == wipe_halted || (m == halted_prog_run && rdy);
      default:         return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Launch and bus sequencing.

  assign cmd_wr    = i_reg_wr && i_reg_addr == `REG_CMD;
  assign running   = mirror inside {whole_array_wipe_run, block_wipe_run, query_wipe_result, halted_prog_run};
  assign launch_sw = cmd_wr && phase == ph_idle &&
                     op_legal(op_t'(i_reg_wdata[3:0]), mirror, status_q[`SR_READY_BIT], dq_q[`DQ_WINDOW_BIT],
                              queue_closed, word_countdown, data_q,
                              addr_q[22:`SECTOR_LSB] == entry_block_addr[22:`SECTOR_LSB]);
  assign launch_poll = !cmd_wr && phase == ph_idle && running && poll_cnt == 8'(`POLL_GAP_CYC);
  assign step      = seq_step(op_q, idx, addr_q, data_q);
  assign fin       = phase == ph_fetch && step[40:39] == `K_END;

  always_ff @(posedge i_clk) begin
    dq_s1 <= i_fl_dq;
    dq_s2 <= dq_s1;
    dq_s3 <= dq_s2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      phase        <= ph_idle;
      op_q         <= 4'h0;
      idx          <= 3'd0;
      strobe_cnt   <= 4'h0;
      kind_q       <= `K_END;
      o_fl_addr    <= `ADDR_ANY;
      o_fl_dq      <= 16'h0000;
      o_fl_dq_oe_n <= 1'b1;
      o_fl_ce_n    <= 1'b1;
      o_fl_we_n    <= 1'b1;
      o_fl_oe_n    <= 1'b1;
      status_q     <= 8'h00;
      dq_q         <= 8'h00;
    end else begin
      case (phase)
        ph_idle: begin
          if (launch_sw || launch_poll) begin
            op_q  <= launch_sw ? op_t'(i_reg_wdata[3:0]) : `OP_POLL;
            idx   <= 3'd0;
            phase <= ph_fetch;
          end
        end
        ph_fetch: begin
          if (step[40:39] == `K_END) begin
            phase <= ph_idle;
          end else begin
            kind_q       <= step[40:39];
            o_fl_addr    <= step[38:16];
            o_fl_dq      <= step[15:0];
            o_fl_ce_n    <= 1'b0;
            o_fl_dq_oe_n <= step[40:39] != `K_WRITE;
            o_fl_we_n    <= step[40:39] != `K_WRITE;
            o_fl_oe_n    <= step[40:39] == `K_WRITE;
            strobe_cnt   <= 4'h0;
            phase        <= ph_strobe;
          end
        end
        ph_strobe: begin
          if (kind_q == `K_WRITE && strobe_cnt == 4'(`WR_STROBE_CYC - 1)) begin
            o_fl_we_n <= 1'b1;
            phase     <= ph_gap;
          end else if (kind_q != `K_WRITE && strobe_cnt >= 4'(`RD_STROBE_CYC - 1) && dq_s2 == dq_s3) begin
            o_fl_oe_n <= 1'b1;
            phase     <= ph_gap;
            if (kind_q == `K_READ_SR) status_q <= dq_s3[7:0];
            else dq_q <= dq_s3[7:0];
          end else begin
            strobe_cnt <= strobe_cnt + 4'h1;
          end
        end
        ph_gap: begin
          o_fl_ce_n    <= 1'b1;
          o_fl_dq_oe_n <= 1'b1;
          idx          <= idx + 3'd1;
          phase        <= ph_fetch;
        end
        default: phase <= ph_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the device's command state.

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mirror           <= read_idle;
      queue_closed     <= 1'b0;
      hang_in_halt     <= 1'b0;
      word_countdown   <= 8'hff;
      entry_block_addr <= `ADDR_ANY;
      lat_cnt          <= 12'h000;
    end else begin
      lat_cnt <= (mirror == wipe_halt_pending || mirror == halted_prog_pause_pending) ? lat_cnt + 12'h001 : 12'h000;
      if (mirror == wipe_halt_pending && lat_cnt == 12'(`HALT_LATENCY_CYC - 1)) begin
        mirror <= wipe_halted;
      end else if (mirror == halted_prog_pause_pending && lat_cnt == 12'(`PAUSE_LATENCY_CYC - 1)) begin
        mirror <= halted_prog_paused;
      end else if (fin) begin
        case (op_q)
          `OP_CHIP: mirror <= whole_array_wipe_run;
          `OP_BLOCK: begin
            mirror       <= block_wipe_run;
            queue_closed <= 1'b0;
          end
          `OP_SUSPEND: begin
            if (mirror == block_wipe_run) begin
              mirror <= wipe_halt_pending;
              if (!dq_q[`DQ_WINDOW_BIT]) queue_closed <= 1'b1;
            end else begin
              mirror <= halted_prog_pause_pending;
            end
          end
          `OP_PAUSE: mirror <= halted_prog_pause_pending;
          `OP_RESUME: mirror <= block_wipe_run;
          `OP_WORD, `OP_BUF_CONFIRM, `OP_PROG_RESUME: mirror <= halted_prog_run;
          `OP_BUF_OPEN: begin
            mirror           <= halted_buffer_load_words;
            word_countdown   <= data_q[7:0];
            entry_block_addr <= addr_q;
          end
          `OP_BUF_WORD: word_countdown <= word_countdown - 8'h01;
          `OP_RESET: begin
            if (mirror == wipe_hang) mirror <= hang_in_halt ? wipe_halted : read_idle;
            else if (mirror == halted_prog_run) mirror <= wipe_halted;
          end
          `OP_QUERY: mirror <= query_wipe_result;
          `OP_POLL: begin
            if (running && status_q[`SR_READY_BIT]) begin
              if (dq_q[`DQ_TIME_LIMIT_BIT]) begin
                mirror       <= wipe_hang;
                hang_in_halt <= mirror == halted_prog_run;
              end else begin
                mirror <= (mirror == halted_prog_run) ? wipe_halted : read_idle;
              end
            end
          end
          default: mirror <= mirror;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || phase != ph_idle || !running) poll_cnt <= 8'h00;
    else if (poll_cnt != 8'(`POLL_GAP_CYC)) poll_cnt <= poll_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers and interrupt.

  always_comb begin
    ev              = 4'h0;
    ev[`EV_DONE]    = fin && op_q == `OP_POLL && running && status_q[`SR_READY_BIT] && !dq_q[`DQ_TIME_LIMIT_BIT];
    ev[`EV_HANG]    = fin && op_q == `OP_POLL && running && status_q[`SR_READY_BIT] && dq_q[`DQ_TIME_LIMIT_BIT];
    ev[`EV_REFUSED] = cmd_wr && !launch_sw;
    ev[`EV_HALTED]  = (mirror == wipe_halt_pending && lat_cnt == 12'(`HALT_LATENCY_CYC - 1)) ||
                      (mirror == halted_prog_pause_pending && lat_cnt == 12'(`PAUSE_LATENCY_CYC - 1));
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      addr_q   <= `ADDR_ANY;
      data_q   <= 16'h0000;
      irq_mask <= 4'h0;
    end else if (i_reg_wr && phase == ph_idle) begin
      if (i_reg_addr == `REG_ADDR) addr_q <= i_reg_wdata[22:0];
      if (i_reg_addr == `REG_DATA) data_q <= i_reg_wdata[15:0];
      if (i_reg_addr == `REG_IRQ_MASK) irq_mask <= i_reg_wdata[3:0];
    end else if (i_reg_wr && i_reg_addr == `REG_IRQ_MASK) begin
      irq_mask <= i_reg_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) irq_stat <= 4'h0;
    else irq_stat <= (irq_stat & ~((i_reg_wr && i_reg_addr == `REG_IRQ_STAT) ? i_reg_wdata[3:0] : 4'h0)) | ev;
  end

  assign o_irq = |(irq_stat & irq_mask);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_ADDR:     o_reg_rdata <= {9'h000, addr_q};
        `REG_DATA:     o_reg_rdata <= {16'h0000, data_q};
        `REG_STATE:    o_reg_rdata <= {16'h0000, word_countdown, 2'b00, queue_closed, phase != ph_idle, mirror};
        `REG_RESULT:   o_reg_rdata <= {16'h0000, dq_q, status_q};
        `REG_IRQ_STAT: o_reg_rdata <= {28'h0000000, irq_stat};
        `REG_IRQ_MASK: o_reg_rdata <= {28'h0000000, irq_mask};
        default:       o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end

endmodule

// [dv/wipe_host_props.sv]
// Checker for the register port and flash pins of the wipe host controller.
`timescale 1ns/100ps
`include "wipe_host_defines.svh"

module wipe_host_props (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [3:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_irq,
  input wire logic [22:0] o_fl_addr,
  input wire logic [15:0] o_fl_dq,
  input wire logic        o_fl_dq_oe_n,
  input wire logic        o_fl_ce_n,
  input wire logic        o_fl_we_n,
  input wire logic        o_fl_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_we_low; (!o_fl_we_n) [*5]; endsequence
  sequence s_we_end; (o_fl_we_n && !o_fl_ce_n) ##1 (o_fl_ce_n && o_fl_dq_oe_n); endsequence
  property p_we_pulse; $fell(o_fl_we_n) |-> s_we_low ##1 s_we_end; endproperty
  property p_we_drive; !o_fl_we_n |-> !o_fl_ce_n && !o_fl_dq_oe_n && o_fl_oe_n; endproperty
  property p_we_hold; !o_fl_we_n && !$fell(o_fl_we_n) |-> $stable(o_fl_addr) && $stable(o_fl_dq); endproperty
  property p_rd_bus; !o_fl_oe_n |-> o_fl_dq_oe_n && !o_fl_ce_n && o_fl_we_n; endproperty
  property p_rd_len; $fell(o_fl_oe_n) |-> (!o_fl_oe_n) [*8]; endproperty
  property p_step_gap; $rose(o_fl_ce_n) |-> $past(o_fl_we_n) && $past(o_fl_oe_n); endproperty
  property p_rdata_slot; o_reg_rdata != 32'h0 |-> $past(i_reg_rd); endproperty
  property p_state_high; $past(i_reg_rd) && $past(i_reg_addr) == `REG_STATE |-> o_reg_rdata[31:16] == 16'h0;
  endproperty
  property p_irq_mask; i_reg_wr && i_reg_addr == `REG_IRQ_MASK && i_reg_wdata[3:0] == 4'h0 |=> !o_irq; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe shape wrong");
  a_we_drive: assert property (p_we_drive) else $error("write strobe without drive");
  a_we_hold: assert property (p_we_hold) else $error("address or data moved in write");
  a_rd_bus: assert property (p_rd_bus) else $error("read strobe with drive");
  a_rd_len: assert property (p_rd_len) else $error("read strobe too short");
  a_step_gap: assert property (p_step_gap) else $error("deselect before strobe ended");
  a_rdata_slot: assert property (p_rdata_slot) else $error("read data outside slot");
  a_state_high: assert property (p_state_high) else $error("state word high bits set");
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with mask clear");
endmodule

bind wipe_host wipe_host_props u_props (.i_clk, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
  .o_reg_rdata, .o_irq, .o_fl_addr, .o_fl_dq, .o_fl_dq_oe_n, .o_fl_ce_n, .o_fl_we_n, .o_fl_oe_n);

// [dv/flash_model.sv]
// Behavioural flash device answering wipe, halt and status command writes.
`timescale 1ns/100ps

module flash_model #(
  parameter int RUN_CYC = 600,
  parameter int WIN_CYC = 150
) (
  input  wire logic        i_clk,
  input  wire logic        i_fail,
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic [15:0]      o_dq
);
  logic we_q = 1'b1, oe_q = 1'b1, run = 1'b0, halted = 1'b0, hang = 1'b0;
  logic setup = 1'b0, sr_mode = 1'b0, qclosed = 1'b0;
  int   ul = 0, left = 0;
  logic [7:0]  cmd;
  logic [15:0] last = 16'h0000, dq_r = 16'h0000, rd_val;
  assign cmd = i_dq[7:0];
  assign o_dq = dq_r;
  // Data-poll byte carries ready, time limit and wipe window flags.
  assign rd_val = sr_mode ? {8'h00, !run, 7'h00} :
                  {8'h00, !run, 1'b0, hang, 1'b0, (RUN_CYC - left) > WIN_CYC || qclosed, 3'h0};
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    we_q <= i_we_n;
    oe_q <= i_oe_n;
    // A released bus shows the inverse of the last value, never a stale copy.
    if (!i_ce_n && !i_oe_n) begin
      dq_r <= rd_val;
      last <= rd_val;
    end else begin
      dq_r <= ~last;
    end
    if (i_oe_n && !oe_q) sr_mode <= 1'b0;
    if (run && left > 0) left <= left - 1;
    if (run && left == 1) begin
      run <= 1'b0;
      hang <= i_fail;
    end
    if (i_we_n && !we_q && !i_ce_n) begin
      if (cmd == 8'hf0) begin
        ul <= 0;
        setup <= 1'b0;
        hang <= 1'b0;
      end else if (cmd == 8'haa && i_addr == 23'h000555) ul <= 1;
      else if (cmd == 8'h55 && i_addr == 23'h0002aa && ul == 1) ul <= 2;
      else if (cmd == 8'h80 && ul == 2) begin
        setup <= 1'b1;
        ul <= 0;
      end else if ((cmd == 8'h10 || cmd == 8'h30) && ul == 2 && setup) begin
        run <= 1'b1;
        left <= RUN_CYC;
        setup <= 1'b0;
        ul <= 0;
        qclosed <= 1'b0;
      end else if (cmd == 8'h30 && halted) begin
        halted <= 1'b0;
        run <= 1'b1;
      end else if (cmd == 8'hb0 && run) begin
        run <= 1'b0;
        halted <= 1'b1;
        qclosed <= 1'b1;
      end else if (cmd == 8'h70) sr_mode <= 1'b1;
      else ul <= 0;
    end
  end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the wipe host controller against a behavioural flash.
`timescale 1ns/100ps
`include "wipe_host_defines.svh"

module tb_top;
  import wipe_host_pkg::*;
  logic i_clk = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, fail = 1'b0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, v, r;
  logic [22:0] o_fl_addr;
  logic [15:0] o_fl_dq, i_fl_dq;
  logic o_irq, o_fl_dq_oe_n, o_fl_ce_n, o_fl_we_n, o_fl_oe_n;
  int bad_count = 0, tests_run = 0, cycles = 0;

  wipe_host u_dut (.i_clk, .i_reset_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_irq,
    .o_fl_addr, .o_fl_dq, .o_fl_dq_oe_n, .i_fl_dq, .o_fl_ce_n, .o_fl_we_n, .o_fl_oe_n);
  flash_model u_flash (.i_clk(i_clk), .i_fail(fail), .i_addr(o_fl_addr), .i_dq(o_fl_dq), .i_ce_n(o_fl_ce_n),
    .i_we_n(o_fl_we_n), .i_oe_n(o_fl_oe_n), .o_dq(i_fl_dq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Polls the state word until the mirror shows the state with the sequencer idle.
  task automatic wait_state(input mirror_e s);
    v = 32'hffffffff;
    for (int n = 0; n < 4000 && v[4:0] !== {1'b0, s}; n++) rd(`REG_STATE, v);
    check({27'h0, v[4:0]}, {27'h0, 1'b0, s});
  endtask
  task automatic op(input op_t c);
    wr(`REG_CMD, {28'h0, c});
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(`REG_STATE, v);
    check(v, 32'h0000ff00);
    rd(4'h7, v);
    check(v, 32'h0);
    wr(`REG_IRQ_MASK, 32'hf);
    rd(`REG_IRQ_MASK, v);
    check(v, 32'hf);
    $display("test reset done");
    wr(`REG_ADDR, 32'h000b8000);
    op(`OP_BLOCK);
    wait_state(block_wipe_run);
    op(`OP_SUSPEND);
    wait_state(wipe_halted);
    check({31'h0, u_flash.halted}, 32'h1);
    rd(`REG_STATE, v);
    check({31'h0, v[5]}, 32'h1);
    rd(`REG_IRQ_STAT, v);
    check(v, 32'h8);
    check({31'h0, o_irq}, 32'h1);
    $display("test halt done");
    rd(`REG_RESULT, r);
    op(`OP_SR_CLEAR);
    wait_state(wipe_halted);
    rd(`REG_RESULT, v);
    check(v, r);
    op(`OP_CHIP);
    rd(`REG_IRQ_STAT, v);
    check(v, 32'hc);
    wr(`REG_IRQ_MASK, 32'h0);
    #1;
    check({31'h0, o_irq}, 32'h0);
    wr(`REG_IRQ_STAT, 32'hf);
    rd(`REG_IRQ_STAT, v);
    check(v, 32'h0);
    wr(`REG_IRQ_MASK, 32'hf);
    wait_state(wipe_halted);
    $display("test refusal done");
    op(`OP_RESUME);
    wait_state(block_wipe_run);
    op(`OP_QUEUE);
    rd(`REG_IRQ_STAT, v);
    check(v & 32'h4, 32'h4);
    wait_state(read_idle);
    rd(`REG_IRQ_STAT, v);
    check(v & 32'h1, 32'h1);
    $display("test resume done");
    fail <= 1'b1;
    op(`OP_CHIP);
    wait_state(wipe_hang);
    rd(`REG_IRQ_STAT, v);
    check(v & 32'h2, 32'h2);
    op(`OP_RESET);
    wait_state(read_idle);
    fail <= 1'b0;
    $display("test hang done");
    results();
  end
endmodule
